//--- board_model.sv
/*
 Board model: open-drain reset pin with pull-up, supply and oscillator.
 Assumes bench commands are levels changed after core_clk edges.
*/
`timescale 1ns/10ps
module board_model (
   // Clock
   input  wire logic       core_clk,
   // Bench commands
   input  wire logic       pinPull,
   input  wire logic       powerUp,
   input  wire logic       lvFall,
   input  wire logic       lvRise,
   // Device side
   input  wire logic       extRstOe,
   output logic            extRstInN,
   output rw_pkg::supply_t supply
);
   logic [2:0] rampCnt_r;

   ////////////////////////////////////////////////////////////////////////////
   // Pull-up with wired-AND of all drivers
   assign extRstInN = !(extRstOe || pinPull);

   always_ff @(posedge core_clk) begin
      if (!powerUp) begin
         rampCnt_r <= 3'h0;
      end else if (rampCnt_r != 3'h7) begin
         rampCnt_r <= rampCnt_r + 3'h1;
      end
   end

   // Detector first, oscillator later
   assign supply.porActive    = rampCnt_r < 3'h3;
   assign supply.oscRunning   = rampCnt_r > 3'h3;
   assign supply.belowFallRef = lvFall || !powerUp;
   assign supply.belowRiseRef = lvRise || lvFall || !powerUp;
endmodule

//--- mcu_reset_and_watchdog.sv
/*
 Reset sequencer and digital watchdog with an AXI4-Lite register slave.
 Assumes supply and oscillator status arrive as synchronous levels and CPU
 events as one-cycle pulses; the external reset pin is an open-drain line.
*/
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module mcu_reset_and_watchdog #(
   parameter int StabCycles = rw_pkg::STAB_CYCLES,
   parameter bit HwActivate = 1'b0,
   parameter bit ExtStopCtl = 1'b0,
   parameter bit LvdEnable  = 1'b1
) (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            srst,
   // AXI4-Lite write
   input  wire logic            awvalid,
   output logic                 awready,
   input  wire logic [7:0]      awaddr,
   input  wire logic            wvalid,
   output logic                 wready,
   input  wire logic [31:0]     wdata,
   input  wire logic [3:0]      wstrb,
   output logic                 bvalid,
   input  wire logic            bready,
   output logic [1:0]           bresp,
   // AXI4-Lite read
   input  wire logic            arvalid,
   output logic                 arready,
   input  wire logic [7:0]      araddr,
   output logic                 rvalid,
   input  wire logic            rready,
   output logic [31:0]          rdata,
   output logic [1:0]           rresp,
   // Reset pin, open drain
   input  wire logic            extRstInN,
   output logic                 extRstOutN,
   output logic                 extRstOe,
   // Supply, oscillator and NMI
   input  wire rw_pkg::supply_t supply,
   input  wire logic            nmiPin,
   // Core side
   input  wire rw_pkg::cpu_evt_t cpuEvt,
   output rw_pkg::core_ctl_t    coreCtl,
   output logic [11:0]          pcVector
);
   localparam int SW = $clog2(StabCycles + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   rw_pkg::seq_state_t state_r;
   rw_pkg::seq_state_t state_nxt;
   logic [SW-1:0]      stabCnt_r;
   logic               pinMeta_r;
   logic               pinSync_r;
   logic               lvdHold_r;
   logic [3:0]         pulseCnt_r;
   logic [3:0]         cause_r;
   logic               nmiMode_r;
   logic               stop_r;
   logic               wait_r;
   logic               serviceIrq_r;
   logic               nextSeq_r;
   logic               bvalid_r;
   logic [1:0]         bresp_r;
   logic               rvalid_r;
   logic [31:0]        rdata_r;
   logic [1:0]         rresp_r;
   logic               wdgTick;
   logic [7:0]         wdgReg;
   logic               wdgArmed;
   logic               wdgFire;
   logic               softFire;
   rw_pkg::status_t    status;

   ////////////////////////////////////////////////////////////////////////////
   // Reset sources
   wire logic pinLow    = ~pinSync_r;
   wire logic pulseHold = (pulseCnt_r != 4'h0) | wdgFire | softFire;
   wire logic intHold   = supply.porActive | lvdHold_r | (pulseCnt_r != 4'h0);
   wire logic anySrc    = pinLow | supply.porActive | lvdHold_r | pulseHold;
   wire logic [3:0] srcVec = {wdgFire | softFire | (pulseCnt_r != 4'h0),
                              lvdHold_r, supply.porActive, pinLow};
   wire logic stHold    = (state_r == rw_pkg::ST_HOLD);
   wire logic stStab    = (state_r == rw_pkg::ST_STAB);
   wire logic stInit    = (state_r == rw_pkg::ST_INIT);
   wire logic stRun     = (state_r == rw_pkg::ST_RUN);
   wire logic devRst    = stHold | stStab;
   wire logic enterHold = anySrc & ~stHold;

   assign extRstOutN = 1'b0;
   assign extRstOe   = intHold;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pinMeta_r <= 1'b1;
         pinSync_r <= 1'b1;
      end else begin
         pinMeta_r <= extRstInN;
         pinSync_r <= pinMeta_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         lvdHold_r <= LvdEnable;
      end else if (!LvdEnable) begin
         lvdHold_r <= 1'b0;
      end else if (supply.belowFallRef) begin
         lvdHold_r <= 1'b1;
      end else if (!supply.belowRiseRef) begin
         lvdHold_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pulseCnt_r <= 4'h0;
      end else if (wdgFire || softFire) begin
         pulseCnt_r <= rw_pkg::PULSE_HOLD;
      end else if (pulseCnt_r != 4'h0) begin
         pulseCnt_r <= pulseCnt_r - 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rw_pkg::ST_HOLD: begin
            if (!anySrc && supply.oscRunning) begin
               state_nxt = rw_pkg::ST_STAB;
            end
         end
         rw_pkg::ST_STAB: begin
            if (anySrc) begin
               state_nxt = rw_pkg::ST_HOLD;
            end else if (stabCnt_r == '0) begin
               state_nxt = rw_pkg::ST_INIT;
            end
         end
         rw_pkg::ST_INIT: begin
            state_nxt = anySrc ? rw_pkg::ST_HOLD : rw_pkg::ST_RUN;
         end
         rw_pkg::ST_RUN: begin
            if (anySrc) begin
               state_nxt = rw_pkg::ST_HOLD;
            end
         end
         default: begin
            state_nxt = rw_pkg::ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r   <= rw_pkg::ST_HOLD;
         stabCnt_r <= SW'(StabCycles - 1);
      end else begin
         state_r <= state_nxt;
         if (stHold) begin
            stabCnt_r <= SW'(StabCycles - 1);
         end else if (stStab && stabCnt_r != '0) begin
            stabCnt_r <= stabCnt_r - SW'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cause_r <= 4'h0;
      end else if (enterHold) begin
         cause_r <= srcVec;
      end else if (stHold) begin
         cause_r <= cause_r | srcVec;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core modes
   wire logic stopOk = ~wdgArmed | (ExtStopCtl & nmiPin);

   always_ff @(posedge core_clk) begin
      if (srst || !stRun) begin
         stop_r <= 1'b0;
         wait_r <= 1'b0;
      end else if (cpuEvt.irqWake) begin
         stop_r <= 1'b0;
         wait_r <= 1'b0;
      end else if (cpuEvt.stopReq && !stop_r && !wait_r) begin
         stop_r <= stopOk;
         wait_r <= ~stopOk;
      end else if (cpuEvt.waitReq && !stop_r) begin
         wait_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || !stRun) begin
         nmiMode_r    <= 1'b1;
         serviceIrq_r <= 1'b0;
         nextSeq_r    <= 1'b0;
      end else begin
         serviceIrq_r <= cpuEvt.intReturn & nmiMode_r & cpuEvt.irqPending;
         nextSeq_r    <= cpuEvt.intReturn & nmiMode_r & ~cpuEvt.irqPending;
         if (cpuEvt.intReturn) begin
            nmiMode_r <= 1'b0;
         end
      end
   end

   assign coreCtl.coreReset   = devRst;
   assign coreCtl.ioPullup    = devRst;
   assign coreCtl.oscStart    = stHold;
   assign coreCtl.arTimerStop = devRst | stInit;
   assign coreCtl.pcLoad      = stInit;
   assign coreCtl.stackClear  = stInit;
   assign coreCtl.nmiMode     = nmiMode_r;
   assign coreCtl.serviceIrq  = serviceIrq_r;
   assign coreCtl.nextSeq     = nextSeq_r;
   assign coreCtl.stopMode    = stop_r;
   assign coreCtl.waitMode    = wait_r;
   assign pcVector            = rw_pkg::RESET_VECTOR;

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   rw_tick_div #(
      .Div (rw_pkg::WDG_DIV)
   ) uDiv (
      .clk  (core_clk),
      .srst (srst),
      .tick (wdgTick)
   );

   wire logic wrFire  = awvalid & wvalid & ~bvalid_r;
   wire logic wrWdg   = wrFire & (awaddr == rw_pkg::WDG_CTRL_ADDR) & wstrb[0];
   wire logic wrMap   = (awaddr == rw_pkg::WDG_CTRL_ADDR) | (awaddr == rw_pkg::STATUS_ADDR);
   wire logic rdFire  = arvalid & ~rvalid_r;
   wire logic rdWdg   = (araddr == rw_pkg::WDG_CTRL_ADDR);
   wire logic rdStat  = (araddr == rw_pkg::STATUS_ADDR);

   rw_wdg_counter #(
      .HwActivate (HwActivate)
   ) uWdg (
      .clk      (core_clk),
      .srst     (srst),
      .devRst   (devRst),
      .tick     (wdgTick),
      .freeze   (stop_r),
      .wrEn     (wrWdg),
      .wrData   (wdata[7:0]),
      .regVal   (wdgReg),
      .armed    (wdgArmed),
      .wdgFire  (wdgFire),
      .softFire (softFire)
   );

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   assign status  = '{causeWdg: cause_r[3], causeLvd: cause_r[2], causePor: cause_r[1],
                      causePin: cause_r[0], waitMode: wait_r, stopMode: stop_r,
                      nmiMode: nmiMode_r, wdgArmed: wdgArmed};
   assign awready = wrFire;
   assign wready  = wrFire;
   assign arready = ~rvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= rw_pkg::RESP_OKAY;
      end else if (wrFire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wrMap ? rw_pkg::RESP_OKAY : rw_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= rw_pkg::RESP_OKAY;
      end else if (rdFire) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rdWdg ? {24'h00_0000, wdgReg} :
                     rdStat ? {24'h00_0000, status} : 32'h0000_0000;
         rresp_r  <= (rdWdg | rdStat) ? rw_pkg::RESP_OKAY : rw_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_pinHold;
      @(posedge core_clk) disable iff (srst) pinLow |=> stHold;
   endproperty
   a_pinHold: assert property (p_pinHold) else $error("pin low did not hold reset");

   property p_shortPulse;
      @(posedge core_clk) disable iff (srst) $fell(pinSync_r) ##1 $rose(pinSync_r) |-> stHold;
   endproperty
   a_shortPulse: assert property (p_shortPulse) else $error("short pin pulse lost");

   sequence s_stabDone;
      stStab && stabCnt_r == '0 && !anySrc;
   endsequence
   property p_stabToInit;
      @(posedge core_clk) disable iff (srst) s_stabDone |=> stInit ##1 (stRun || stHold);
   endproperty
   a_stabToInit: assert property (p_stabToInit) else $error("init did not follow delay");

   property p_noEarlyInit;
      @(posedge core_clk) disable iff (srst) (stStab && stabCnt_r != '0) |=> !stInit;
   endproperty
   a_noEarlyInit: assert property (p_noEarlyInit) else $error("init before delay end");

   property p_pinDrive;
      @(posedge core_clk) disable iff (srst)
         (supply.porActive || lvdHold_r) |-> (extRstOe && !extRstOutN) ##1 coreCtl.coreReset;
   endproperty
   a_pinDrive: assert property (p_pinDrive) else $error("internal reset not on pin");

   sequence s_wdgHold;
      (extRstOe && !stRun) [*2];
   endsequence
   property p_wdgReset;
      @(posedge core_clk) disable iff (srst) (wdgFire || softFire) |=> s_wdgHold;
   endproperty
   a_wdgReset: assert property (p_wdgReset) else $error("watchdog fire did not reset");

   property p_lvdHyst;
      @(posedge core_clk) disable iff (srst)
         (LvdEnable && lvdHold_r && supply.belowRiseRef) |=> lvdHold_r;
   endproperty
   a_lvdHyst: assert property (p_lvdHyst) else $error("low-voltage hold released early");

   property p_initVector;
      @(posedge core_clk) disable iff (srst)
         stInit |-> coreCtl.pcLoad && coreCtl.stackClear && pcVector == 12'hFFE && nmiMode_r;
   endproperty
   a_initVector: assert property (p_initVector) else $error("bad init load");

   property p_irqReturn;
      @(posedge core_clk) disable iff (srst)
         (stRun && nmiMode_r && cpuEvt.intReturn && cpuEvt.irqPending) ##1 stRun
         |-> serviceIrq_r && !nextSeq_r && !nmiMode_r;
   endproperty
   a_irqReturn: assert property (p_irqReturn) else $error("pending interrupt skipped");

   property p_extStop;
      @(posedge core_clk) disable iff (srst)
         (stRun && ExtStopCtl && wdgArmed && nmiPin && cpuEvt.stopReq && !cpuEvt.irqWake
          && !stop_r && !wait_r && !anySrc) |=> stop_r && !wait_r;
   endproperty
   a_extStop: assert property (p_extStop) else $error("stop gating wrong");

   property p_arTimer;
      @(posedge core_clk) disable iff (srst) devRst |-> coreCtl.arTimerStop;
   endproperty
   a_arTimer: assert property (p_arTimer) else $error("timer not stopped in reset");
endmodule

//--- rw_pkg.sv
/*
 Shared constants, types and helpers for the reset sequencer and watchdog.
 Assumes a single core clock and AXI4-Lite register access with 32-bit data.
*/
package rw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam logic [7:0]  WDG_CTRL_ADDR = 8'hD8;
   localparam logic [7:0]  STATUS_ADDR   = 8'hDC;
   localparam logic [7:0]  WDG_CTRL_RST  = 8'hFE;
   localparam logic [6:0]  WDG_CNT_RST   = 7'h7F;
   localparam int          ARM_BIT       = 0;
   localparam int          SR_BIT        = 1;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int          WDG_DIV       = 12;
   localparam int          STAB_CYCLES   = 2048;
   localparam logic [3:0]  PULSE_HOLD    = 4'h8;
   localparam logic [11:0] RESET_VECTOR  = 12'hFFE;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {ST_HOLD, ST_STAB, ST_INIT, ST_RUN} seq_state_t;

   typedef struct packed {
      logic porActive;
      logic belowFallRef;
      logic belowRiseRef;
      logic oscRunning;
   } supply_t;

   typedef struct packed {
      logic stopReq;
      logic waitReq;
      logic irqWake;
      logic intReturn;
      logic irqPending;
   } cpu_evt_t;

   typedef struct packed {
      logic coreReset;
      logic ioPullup;
      logic oscStart;
      logic arTimerStop;
      logic pcLoad;
      logic stackClear;
      logic nmiMode;
      logic serviceIrq;
      logic nextSeq;
      logic stopMode;
      logic waitMode;
   } core_ctl_t;

   typedef struct packed {
      logic causeWdg;
      logic causeLvd;
      logic causePor;
      logic causePin;
      logic waitMode;
      logic stopMode;
      logic nmiMode;
      logic wdgArmed;
   } status_t;

   ////////////////////////////////////////////////////////////////////////////
   // Register bits run opposite to the physical down-counter
   function automatic logic [5:0] rev6(input logic [5:0] v);
      rev6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
   endfunction

endpackage

//--- rw_tick_div.sv
/*
 Divider producing a one-cycle enable pulse every Div core cycles.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/10ps
module rw_tick_div #(
   parameter int Div = rw_pkg::WDG_DIV
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Divided enable
   output logic      tick
);
   localparam int CW = $clog2(Div);
   logic [CW-1:0] cnt_r;
   wire  logic    wrap = (cnt_r == CW'(Div - 1));

   assign tick = wrap;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= wrap ? '0 : cnt_r + CW'(1);
      end
   end

   property p_tickSpacing;
      @(posedge clk) disable iff (srst) tick |=> !tick [*8];
   endproperty
   a_tickSpacing: assert property (p_tickSpacing) else $error("tick too frequent");
endmodule

//--- rw_wdg_counter.sv
/*
 Watchdog down-counter and its control register image.
 Assumes tick is a one-cycle enable and devRst holds while the device is reset.
*/
`timescale 1ns/10ps
module rw_wdg_counter #(
   parameter bit HwActivate = 1'b0
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       devRst,
   // Count control
   input  wire logic       tick,
   input  wire logic       freeze,
   // Register write
   input  wire logic       wrEn,
   input  wire logic [7:0] wrData,
   // Results
   output logic [7:0]      regVal,
   output logic            armed,
   output logic            wdgFire,
   output logic            softFire
);
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic       armed_r;
   logic       armed_nxt;

   wire logic [6:0] wrCnt   = {wrData[rw_pkg::SR_BIT], rw_pkg::rev6(wrData[7:2])};
   wire logic       countEn = tick & ~freeze & ~devRst;
   wire logic [6:0] decCnt  = cnt_r - 7'h01;

   assign armed_nxt = HwActivate | armed_r | (wrEn & wrData[rw_pkg::ARM_BIT]);
   assign cnt_nxt   = wrEn ? wrCnt : (countEn ? decCnt : cnt_r);
   assign wdgFire   = armed_r & countEn & ~wrEn & cnt_r[6] & ~decCnt[6];
   assign softFire  = wrEn & armed_nxt & ~wrData[rw_pkg::SR_BIT] & ~devRst;
   assign regVal    = {rw_pkg::rev6(cnt_r[5:0]), cnt_r[6], armed_r};
   assign armed     = armed_r;

   always_ff @(posedge clk) begin
      if (srst || devRst) begin
         cnt_r   <= rw_pkg::WDG_CNT_RST;
         armed_r <= HwActivate;
      end else begin
         cnt_r   <= cnt_nxt;
         armed_r <= armed_nxt;
      end
   end

   property p_reinit;
      @(posedge clk) disable iff (srst) devRst |=> regVal[7:1] == 7'h7F;
   endproperty
   a_reinit: assert property (p_reinit) else $error("watchdog not reloaded by reset");

   property p_freeze;
      @(posedge clk) disable iff (srst) (freeze && !wrEn && !devRst) |=> $stable(cnt_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("counter moved while frozen");
endmodule

//--- tb.sv
/*
 Self-checking bench for the reset sequencer and watchdog.
 Assumes board_model drives the reset pin and supply.
*/
`timescale 1ns/10ps
module tb;
   logic              core_clk, srst, awvalid, wvalid, bready, arvalid, rready;
   logic              awready, wready, bvalid, arready, rvalid, nmiPin;
   logic              extRstInN, extRstOutN, extRstOe, pinPull, powerUp, lvFall, lvRise;
   logic [7:0]        awaddr, araddr;
   logic [31:0]       wdata, rdata, rd;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, rs;
   logic [11:0]       pcVector;
   rw_pkg::supply_t   supply;
   rw_pkg::cpu_evt_t  cpuEvt;
   rw_pkg::core_ctl_t coreCtl, coreCtlHw, seen;
   int                mismatches, check_count, n, t;
   longint            t0;

   mcu_reset_and_watchdog #(.StabCycles(8)) mcu_reset_and_watchdog_i (
      .core_clk(core_clk), .srst(srst), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .extRstInN(extRstInN), .extRstOutN(extRstOutN),
      .extRstOe(extRstOe), .supply(supply), .nmiPin(nmiPin), .cpuEvt(cpuEvt),
      .coreCtl(coreCtl), .pcVector(pcVector));

   // Hardware activation with NMI stop gating, fed the same stimulus
   mcu_reset_and_watchdog #(.StabCycles(8), .HwActivate(1'b1), .ExtStopCtl(1'b1))
      mcu_reset_and_watchdog_hw_i (
      .core_clk(core_clk), .srst(srst), .awvalid(awvalid), .awready(),
      .awaddr(awaddr), .wvalid(wvalid), .wready(), .wdata(wdata), .wstrb(wstrb),
      .bvalid(), .bready(bready), .bresp(), .arvalid(arvalid),
      .arready(), .araddr(araddr), .rvalid(), .rready(rready),
      .rdata(), .rresp(), .extRstInN(extRstInN), .extRstOutN(),
      .extRstOe(), .supply(supply), .nmiPin(nmiPin), .cpuEvt(cpuEvt),
      .coreCtl(coreCtlHw), .pcVector());

   board_model board_model_i (
      .core_clk(core_clk), .pinPull(pinPull), .powerUp(powerUp), .lvFall(lvFall),
      .lvRise(lvRise), .extRstOe(extRstOe), .extRstInN(extRstInN), .supply(supply));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input bit ok, input string m);
      check_count++;
      if (!ok) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic step(inout int k);
      @(posedge core_clk);
      k++;
      if (k > 400) begin
         chk(1'b0, "timeout");
         end_of_test();
      end
   endtask

   task automatic wait_rst(input logic lv);
      n = 0;
      while (coreCtl.coreReset !== lv) step(n);
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge core_clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      do step(k); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do step(k); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      int k = 0;
      @(posedge core_clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do step(k); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do step(k); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic pulse(input logic [4:0] e);
      @(posedge core_clk);
      cpuEvt <= rw_pkg::cpu_evt_t'(e);
      @(posedge core_clk);
      cpuEvt <= rw_pkg::cpu_evt_t'({4'h0, e[0]});
      @(posedge core_clk);
      seen = coreCtl;
      @(posedge core_clk);
   endtask

   task automatic pin(input int len);
      @(posedge core_clk);
      pinPull <= 1'b1;
      repeat (len) @(posedge core_clk);
      pinPull <= 1'b0;
      wait_rst(1'b1);
   endtask

   // Register bits 7..2 hold counter bits 0..5
   function automatic logic [5:0] flip6(input logic [5:0] v);
      for (int i = 0; i < 6; i++) flip6[5 - i] = v[i];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      {srst, pinPull, lvFall, lvRise, powerUp} = 5'h10;
      {awvalid, wvalid, bready, arvalid, rready, nmiPin} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0000_0000, 4'hF};
      cpuEvt = rw_pkg::cpu_evt_t'(5'h00);
      mismatches = 0;
      check_count = 0;
      void'($urandom(32'h9F0E));
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      powerUp <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk(extRstOe === 1'b1 && coreCtl.ioPullup === 1'b1, "power-on hold");
      axi_rd(8'hD8);
      chk(rd === 32'h0000_00FE && rs === rw_pkg::RESP_OKAY, "reset value");
      wait_rst(1'b0);
      chk(n >= 8, "start delay");
      axi_rd(8'h40);
      chk(rd === 32'h0 && rs === rw_pkg::RESP_SLVERR, "unmapped read");
      axi_wr(8'h44, $urandom);
      chk(rs === rw_pkg::RESP_SLVERR, "unmapped write");
      axi_wr(8'hDC, 32'h0000_00FF);
      axi_rd(8'hDC);
      chk(rs === rw_pkg::RESP_OKAY && rd[0] === 1'b0, "status write");
      $display("test bus done");
      for (int i = 0; i < 2; i++) begin
         pin($urandom_range(3, 1));
         chk(coreCtl.oscStart === 1'b1 && coreCtl.arTimerStop === 1'b1, "pin hold");
         wait_rst(1'b0);
         chk(n >= 8, "pin delay");
         chk(coreCtl.pcLoad === 1'b1 && coreCtl.stackClear === 1'b1, "init");
         chk(pcVector === 12'hFFE && coreCtl.nmiMode === 1'b1, "vector");
         pulse({4'h1, i[0]});
         chk((i ? seen.serviceIrq : seen.nextSeq) === 1'b1 &&
             (i ? seen.nextSeq : seen.serviceIrq) === 1'b0, "return pulse");
         chk((i ? coreCtl.serviceIrq : coreCtl.nextSeq) === 1'b0, "pulse width");
         chk(coreCtl.nmiMode === 1'b0, "nmi end");
      end
      $display("test pin done");
      pulse(5'h10);
      chk(coreCtl.stopMode === 1'b1, "stop");
      chk(coreCtlHw.waitMode === 1'b1 && coreCtlHw.stopMode === 1'b0, "hw stop as wait");
      pin(1);
      chk(coreCtl.oscStart === 1'b1 && coreCtl.ioPullup === 1'b1, "stop pin");
      wait_rst(1'b0);
      axi_wr(8'hD8, 32'h0000_00FF);
      pulse(5'h10);
      chk(coreCtl.waitMode === 1'b1 && coreCtl.stopMode === 1'b0, "armed stop");
      pulse(5'h04);
      chk(coreCtl.waitMode === 1'b0, "wake");
      nmiPin <= 1'b1;
      pulse(5'h10);
      chk(coreCtlHw.stopMode === 1'b1 && coreCtl.waitMode === 1'b1, "nmi gated stop");
      pulse(5'h04);
      chk(coreCtlHw.stopMode === 1'b0, "stop wake");
      nmiPin <= 1'b0;
      axi_wr(8'hD8, 32'h0000_00FE);
      axi_rd(8'hDC);
      chk(rd[0] === 1'b1, "arm sticky");
      axi_wr(8'hD8, 32'h0000_00FD);
      n = 0;
      while (extRstOe !== 1'b1 && n < 3) step(n);
      chk(extRstOe === 1'b1 && extRstOutN === 1'b0, "soft reset");
      wait_rst(1'b0);
      $display("test stop done");
      t = $urandom_range(5, 1);
      axi_wr(8'hD8, {24'h0, flip6(t[5:0]), 2'b11});
      n = 0;
      while (extRstOe !== 1'b1) step(n);
      t0 = $time;
      chk(n >= t * 12 - 2 && n <= t * 12 + 14, "period");
      axi_rd(8'hD8);
      chk(rd === 32'h0000_00FE, "reinit");
      axi_rd(8'hDC);
      chk(rd[7] === 1'b1, "cause");
      wait_rst(1'b0);
      chk($time - t0 >= 800, "wdg delay");
      $display("test watchdog done");
      lvRise <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk(coreCtl.coreReset === 1'b0, "no reset");
      lvFall <= 1'b1;
      wait_rst(1'b1);
      chk(extRstOe === 1'b1, "low hold");
      lvFall <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk(coreCtl.coreReset === 1'b1, "hysteresis");
      lvRise <= 1'b0;
      wait_rst(1'b0);
      $display("test low voltage done");
      end_of_test();
   end
endmodule
